// file: include/ldscd_pkg.sv
package ldscd_pkg;

  localparam int CH_N   = 16;
  localparam int WORD_W = 16;
  localparam int PCNT_W = 5;

  // Strobe pulse counts per command
  localparam logic [4:0] PULSE_STAGE_HI   = 5'h01;
  localparam logic [4:0] PULSE_PROMOTE_LO = 5'h02;
  localparam logic [4:0] PULSE_PROMOTE_HI = 5'h03;
  localparam logic [4:0] PULSE_MASK_LO    = 5'h07;
  localparam logic [4:0] PULSE_MASK_HI    = 5'h08;
  localparam logic [4:0] PULSE_DETECT_LO  = 5'h09;
  localparam logic [4:0] PULSE_DETECT_HI  = 5'h0A;
  localparam logic [4:0] PULSE_CRESET_LO  = 5'h0B;
  localparam logic [4:0] PULSE_CRESET_HI  = 5'h0C;
  localparam logic [4:0] PULSE_CFG1_LO    = 5'h0D;
  localparam logic [4:0] PULSE_CFG1_HI    = 5'h0E;
  localparam logic [4:0] PULSE_CFG2_LO    = 5'h0F;
  localparam logic [4:0] PULSE_CFG2_HI    = 5'h10;
  localparam logic [4:0] PULSE_SAT        = 5'h1F;

  // Configuration word fields
  localparam int CFG1_RES_LSB   = 2;
  localparam int CFG2_OPEN_BIT  = 1;
  localparam int CFG2_SHORT_BIT = 2;
  localparam int CFG2_ASYNC_BIT = 3;

  localparam logic [1:0] RES_16 = 2'h0;
  localparam logic [1:0] RES_14 = 2'h1;
  localparam logic [1:0] RES_12 = 2'h2;
  localparam logic [1:0] RES_10 = 2'h3;

  localparam logic [15:0] LIM_16 = 16'hFFFF;
  localparam logic [15:0] LIM_14 = 16'h3FFF;
  localparam logic [15:0] LIM_12 = 16'h0FFF;
  localparam logic [15:0] LIM_10 = 16'h03FF;

  // Reset values
  localparam logic [15:0] CFG1_RST  = 16'h0000;
  localparam logic [15:0] CFG2_RST  = 16'h0000;
  localparam logic [15:0] MASK_RST  = 16'hFFFF;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // Automatic detection window in grayscale steps
  localparam logic [15:0] AUTO_WIN_FIRST = 16'h0001;
  localparam logic [15:0] AUTO_WIN_LAST  = 16'h0015;

  // Manual detection forced-on time
  localparam int DETECT_ON_NS  = 800;
  localparam int CLK_PERIOD_NS = 4;
  localparam int DETECT_ON_CYC = (DETECT_ON_NS / CLK_PERIOD_NS < 1) ? 1 : DETECT_ON_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_COUNT = 2'h1,
    ST_WAIT  = 2'h3
  } ldscd_state_t;

  typedef enum logic [1:0] {
    XK_PROMOTE = 2'h0,
    XK_MASK    = 2'h1,
    XK_RESET   = 2'h2
  } ldscd_xkind_t;

  typedef struct packed {
    logic       async_mode;
    logic [1:0] res;
  } ldscd_pwm_cfg_t;

  typedef struct packed {
    ldscd_xkind_t   kind;
    ldscd_pwm_cfg_t cfg;
  } ldscd_xreq_t;

endpackage

// file: hdl/ldscd_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ldscd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  initial begin
    if (W < 1) $error("ldscd_sync width below one");
  end

  // First stage read only by the second
  always_ff @(posedge clk) begin
    meta <= d;
    q    <= meta;
  end
endmodule
`default_nettype wire

// file: hdl/ldscd_event_xfer.sv
`timescale 1ns/1ps
`default_nettype none
module ldscd_event_xfer (
  input  wire logic clk_src,
  input  wire logic rst_src,
  input  wire logic pulse_src,
  input  wire logic clk_dst,
  input  wire logic rst_dst,
  output logic      pulse_dst
);
  logic tog;
  logic tog_s;
  logic tog_q;

  // Toggle carries the event across
  always_ff @(posedge clk_src) begin
    if (rst_src) begin
      tog <= 1'b0;
    end else if (pulse_src) begin
      tog <= ~tog;
    end
  end

  ldscd_sync #(.W(1)) u_sync (
    .clk (clk_dst),
    .d   (tog),
    .q   (tog_s)
  );

  always_ff @(posedge clk_dst) begin
    if (rst_dst) begin
      tog_q <= 1'b0;
    end else begin
      tog_q <= tog_s;
    end
  end

  assign pulse_dst = tog_s ^ tog_q;
endmodule
`default_nettype wire

// file: hdl/ldscd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module ldscd_decoder
  import ldscd_pkg::*;
#(
  parameter int CHANNELS = CH_N
) (
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  input  wire logic                grayscale_ref_clock,
  input  wire logic                shift_clock,
  input  wire logic                serial_in_line,
  input  wire logic                command_strobe,
  input  wire logic [CHANNELS-1:0] open_detect,
  input  wire logic [CHANNELS-1:0] short_detect,
  output logic                     serial_out_line,
  output logic      [CHANNELS-1:0] sink_channels,
  output logic                     detect_current_on,
  output logic      [WORD_W-1:0]   config_one_word,
  output logic      [WORD_W-1:0]   config_two_word,
  output logic                     command_busy
);

  initial begin
    if (CHANNELS != WORD_W) $error("ldscd_decoder needs one channel per word bit");
  end

  // Input synchronisers
  logic [2:0]          pin_s;
  logic                s_sck;
  logic                s_strobe;
  logic                s_sin;
  logic [CHANNELS-1:0] s_open;
  logic [CHANNELS-1:0] s_short;

  ldscd_sync #(.W(3)) u_pin_sync (
    .clk (clk_sys),
    .d   ({shift_clock, command_strobe, serial_in_line}),
    .q   (pin_s)
  );

  ldscd_sync #(.W(2*CHANNELS)) u_det_sync (
    .clk (clk_sys),
    .d   ({open_detect, short_detect}),
    .q   ({s_open, s_short})
  );

  assign s_sck    = pin_s[2];
  assign s_strobe = pin_s[1];
  assign s_sin    = pin_s[0];

  logic sck_q;
  logic strobe_q;
  logic sck_rise;
  logic strobe_rise;
  logic strobe_fall;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sck_q    <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      sck_q    <= s_sck;
      strobe_q <= s_strobe;
    end
  end

  assign sck_rise    = s_sck & ~sck_q;
  assign strobe_rise = s_strobe & ~strobe_q;
  assign strobe_fall = ~s_strobe & strobe_q;

  // Registers of the system domain
  ldscd_state_t        state;
  logic [PCNT_W-1:0]   pulse_cnt;
  logic [WORD_W-1:0]   shreg;
  logic                skip_in;
  logic [WORD_W-1:0]   stage_gs [CHANNELS];
  logic [3:0]          stage_ptr;
  logic [WORD_W-1:0]   mask_word;
  logic [WORD_W-1:0]   cfg1;
  logic [WORD_W-1:0]   cfg2;
  ldscd_xreq_t         xreq;
  logic [CHANNELS-1:0] auto_open;
  logic [CHANNELS-1:0] auto_short;
  logic [15:0]         det_timer;
  logic                det_run;

  // Decode of the finished command
  logic exec;
  logic do_stage;
  logic do_promote;
  logic do_mask;
  logic do_detect;
  logic do_creset;
  logic do_cfg1;
  logic do_cfg2;
  logic det_done;
  logic load_result;
  logic [WORD_W-1:0] result_word;
  logic fire_req;
  logic ack_pulse;
  logic win_s;
  logic open_en;
  logic short_en;

  assign exec       = (state == ST_COUNT) && strobe_fall;
  assign do_stage   = exec && (pulse_cnt <= PULSE_STAGE_HI);
  assign do_promote = exec && (pulse_cnt >= PULSE_PROMOTE_LO) && (pulse_cnt <= PULSE_PROMOTE_HI);
  assign do_mask    = exec && (pulse_cnt >= PULSE_MASK_LO) && (pulse_cnt <= PULSE_MASK_HI);
  assign do_detect  = exec && (pulse_cnt >= PULSE_DETECT_LO) && (pulse_cnt <= PULSE_DETECT_HI);
  assign do_creset  = exec && (pulse_cnt >= PULSE_CRESET_LO) && (pulse_cnt <= PULSE_CRESET_HI);
  assign do_cfg1    = exec && (pulse_cnt >= PULSE_CFG1_LO) && (pulse_cnt <= PULSE_CFG1_HI);
  assign do_cfg2    = exec && (pulse_cnt >= PULSE_CFG2_LO) && (pulse_cnt <= PULSE_CFG2_HI);
  // Counts 4..6 and above 16 match nothing and fall through
  assign fire_req   = do_promote || do_mask || do_creset;

  assign open_en  = cfg2[CFG2_OPEN_BIT];
  assign short_en = cfg2[CFG2_SHORT_BIT];
  assign det_done = det_run && (det_timer == 16'h0000);

  always_comb begin
    result_word = ~(({CHANNELS{open_en}} & s_open) | ({CHANNELS{short_en}} & s_short));
    load_result = 1'b0;
    if (do_promote && (open_en || short_en)) begin
      result_word = ~(({CHANNELS{open_en}} & auto_open) | ({CHANNELS{short_en}} & auto_short));
      load_result = 1'b1;
    end else if (det_done && (open_en || short_en)) begin
      load_result = 1'b1;
    end
  end

  // Command state
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (strobe_rise) begin
            state <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (strobe_fall) begin
            state <= (fire_req || do_detect) ? ST_WAIT : ST_IDLE;
          end
        end
        ST_WAIT: begin
          if (ack_pulse || det_done) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign command_busy = (state == ST_WAIT);

  // Strobe pulse counter
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pulse_cnt <= '0;
    end else if (strobe_rise) begin
      pulse_cnt <= '0;
    end else if (sck_rise && s_strobe && (pulse_cnt != PULSE_SAT)) begin
      pulse_cnt <= pulse_cnt + 5'h01;
    end
  end

  // Shift register, MSB first
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      shreg   <= WORD_ZERO;
      skip_in <= 1'b0;
    end else if (load_result) begin
      shreg   <= result_word;
      skip_in <= 1'b1;
    end else if (sck_rise && !s_strobe) begin
      shreg   <= {shreg[WORD_W-2:0], (skip_in ? 1'b0 : s_sin)};
      skip_in <= 1'b0;
    end
  end

  assign serial_out_line = shreg[WORD_W-1];

  // Staging grayscale register, one word per load
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stage_ptr <= 4'h0;
      for (int i = 0; i < CHANNELS; i++) begin
        stage_gs[i] <= WORD_ZERO;
      end
    end else if (do_stage) begin
      stage_gs[stage_ptr] <= shreg;
      stage_ptr           <= stage_ptr + 4'h1;
    end else if (do_promote) begin
      stage_ptr <= 4'h0;
    end
  end

  // Mask and configuration words
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mask_word <= MASK_RST;
      cfg1      <= CFG1_RST;
      cfg2      <= CFG2_RST;
    end else begin
      if (do_mask) begin
        mask_word <= shreg;
      end
      if (do_cfg1) begin
        cfg1 <= shreg;
      end
      if (do_cfg2) begin
        cfg2 <= shreg;
      end
    end
  end

  assign config_one_word = cfg1;
  assign config_two_word = cfg2;

  // Request held stable until acknowledged
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      xreq <= '{kind: XK_RESET, cfg: '{async_mode: 1'b0, res: RES_16}};
    end else if (fire_req) begin
      xreq.kind           <= do_promote ? XK_PROMOTE : (do_mask ? XK_MASK : XK_RESET);
      xreq.cfg.async_mode <= cfg2[CFG2_ASYNC_BIT];
      xreq.cfg.res        <= cfg1[CFG1_RES_LSB +: 2];
    end
  end

  // Automatic detection sampled while the window is open
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      auto_open  <= '0;
      auto_short <= '0;
    end else if (win_s) begin
      auto_open  <= s_open;
      auto_short <= s_short;
    end
  end

  // Manual detection forced-on timer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      det_run   <= 1'b0;
      det_timer <= 16'h0000;
    end else if (do_detect) begin
      det_run   <= 1'b1;
      det_timer <= 16'(DETECT_ON_CYC - 1);
    end else if (det_done) begin
      det_run <= 1'b0;
    end else if (det_run) begin
      det_timer <= det_timer - 16'h0001;
    end
  end

  assign detect_current_on = det_run;

  // Crossings to and from the grayscale domain
  logic pwm_rst;
  logic p_req;
  logic p_ack;

  ldscd_sync #(.W(1)) u_rst_sync (
    .clk (grayscale_ref_clock),
    .d   (sys_rst),
    .q   (pwm_rst)
  );

  ldscd_event_xfer u_req_xfer (
    .clk_src   (clk_sys),
    .rst_src   (sys_rst),
    .pulse_src (fire_req),
    .clk_dst   (grayscale_ref_clock),
    .rst_dst   (pwm_rst),
    .pulse_dst (p_req)
  );

  ldscd_event_xfer u_ack_xfer (
    .clk_src   (grayscale_ref_clock),
    .rst_src   (pwm_rst),
    .pulse_src (p_ack),
    .clk_dst   (clk_sys),
    .rst_dst   (sys_rst),
    .pulse_dst (ack_pulse)
  );

  // Grayscale domain
  logic [WORD_W-1:0]   gs_next [CHANNELS];
  logic [WORD_W-1:0]   gs_act  [CHANNELS];
  logic [WORD_W-1:0]   pcnt;
  logic                running;
  logic                pend;
  logic [1:0]          res_act;
  logic [1:0]          res_next;
  logic [CHANNELS-1:0] mask_act;
  logic [CHANNELS-1:0] mask_next;
  logic                mask_pend;
  logic [WORD_W-1:0]   lim;
  logic                cyc_end;
  logic                start_now;
  logic                win_p;

  always_comb begin
    case (res_act)
      RES_16:  lim = LIM_16;
      RES_14:  lim = LIM_14;
      RES_12:  lim = LIM_12;
      RES_10:  lim = LIM_10;
      default: lim = LIM_16;
    endcase
  end

  assign cyc_end   = running && (pcnt == lim - 16'h0001);
  assign start_now = p_req && (xreq.kind == XK_PROMOTE) && (xreq.cfg.async_mode || !running);

  always_ff @(posedge grayscale_ref_clock) begin
    if (pwm_rst) begin
      p_ack <= 1'b0;
    end else begin
      p_ack <= p_req;
    end
  end

  // PWM counter, one step per reference clock
  always_ff @(posedge grayscale_ref_clock) begin
    if (pwm_rst) begin
      running <= 1'b0;
      pcnt    <= WORD_ZERO;
    end else if (p_req && (xreq.kind == XK_RESET)) begin
      running <= 1'b0;
      pcnt    <= WORD_ZERO;
    end else if (start_now) begin
      running <= 1'b1;
      pcnt    <= WORD_ZERO;
    end else if (cyc_end) begin
      running <= pend;
      pcnt    <= WORD_ZERO;
    end else if (running) begin
      pcnt <= pcnt + 16'h0001;
    end
  end

  // Grayscale registers two and three
  always_ff @(posedge grayscale_ref_clock) begin
    if (pwm_rst) begin
      pend     <= 1'b0;
      res_act  <= RES_16;
      res_next <= RES_16;
      for (int i = 0; i < CHANNELS; i++) begin
        gs_next[i] <= WORD_ZERO;
        gs_act[i]  <= WORD_ZERO;
      end
    end else if (p_req && (xreq.kind == XK_RESET)) begin
      pend <= 1'b0;
    end else if (start_now) begin
      pend    <= 1'b0;
      res_act <= xreq.cfg.res;
      for (int i = 0; i < CHANNELS; i++) begin
        gs_act[i] <= stage_gs[i];
      end
    end else if (p_req && (xreq.kind == XK_PROMOTE)) begin
      pend     <= 1'b1;
      res_next <= xreq.cfg.res;
      for (int i = 0; i < CHANNELS; i++) begin
        gs_next[i] <= stage_gs[i];
      end
    end else if (cyc_end && pend) begin
      pend    <= 1'b0;
      res_act <= res_next;
      for (int i = 0; i < CHANNELS; i++) begin
        gs_act[i] <= gs_next[i];
      end
    end
  end

  // On/off mask
  always_ff @(posedge grayscale_ref_clock) begin
    if (pwm_rst) begin
      mask_act  <= MASK_RST;
      mask_next <= MASK_RST;
      mask_pend <= 1'b0;
    end else if (p_req && (xreq.kind == XK_MASK)) begin
      if (xreq.cfg.async_mode || !running) begin
        mask_act  <= mask_word;
        mask_pend <= 1'b0;
      end else begin
        mask_next <= mask_word;
        mask_pend <= 1'b1;
      end
    end else if (cyc_end && mask_pend) begin
      mask_act  <= mask_next;
      mask_pend <= 1'b0;
    end
  end

  // Channel outputs and detection window
  always_ff @(posedge grayscale_ref_clock) begin
    if (pwm_rst) begin
      sink_channels <= '0;
      win_p         <= 1'b0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        sink_channels[i] <= running && mask_act[i] && (pcnt < (gs_act[i] & lim));
      end
      win_p <= running && (pcnt >= AUTO_WIN_FIRST) && (pcnt <= AUTO_WIN_LAST);
    end
  end

  ldscd_sync #(.W(1)) u_win_sync (
    .clk (clk_sys),
    .d   (win_p),
    .q   (win_s)
  );

endmodule
`default_nettype wire

// file: verification/ldscd_decoder_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ldscd_decoder_asserts
  import ldscd_pkg::*;
#(
  parameter int CHANNELS = CH_N
) (
  input wire logic                clk_sys,
  input wire logic                sys_rst,
  input wire logic                grayscale_ref_clock,
  input wire logic                shift_clock,
  input wire logic                serial_in_line,
  input wire logic                command_strobe,
  input wire logic [CHANNELS-1:0] open_detect,
  input wire logic [CHANNELS-1:0] short_detect,
  input wire logic                serial_out_line,
  input wire logic [CHANNELS-1:0] sink_channels,
  input wire logic                detect_current_on,
  input wire logic [WORD_W-1:0]   config_one_word,
  input wire logic [WORD_W-1:0]   config_two_word,
  input wire logic                command_busy
);
  logic       strobe_q;
  logic [8:0] since_fall;
  logic [8:0] on_cnt;

  always_ff @(posedge clk_sys) begin
    strobe_q <= command_strobe;
  end

  // Cycles since the strobe last fell
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      since_fall <= 9'h1FF;
    end else if (strobe_q && !command_strobe) begin
      since_fall <= 9'h000;
    end else if (since_fall != 9'h1FF) begin
      since_fall <= since_fall + 9'h001;
    end
  end

  // Length of the forced-on detect current
  always_ff @(posedge clk_sys) begin
    if (!detect_current_on) begin
      on_cnt <= 9'h000;
    end else if (on_cnt != 9'h1FF) begin
      on_cnt <= on_cnt + 9'h001;
    end
  end

  sequence s_busy_rise;
    $rose(command_busy);
  endsequence

  sequence s_detect_end;
    detect_current_on ##1 !detect_current_on;
  endsequence

  chk_reset_clear: assert property (@(posedge clk_sys)
    sys_rst |=> (config_one_word == CFG1_RST && config_two_word == CFG2_RST && !command_busy && !serial_out_line))
    else $error("state not cleared by reset");
  chk_sink_reset: assert property (@(posedge grayscale_ref_clock)
    sys_rst [*4] |=> sink_channels == '0)
    else $error("channels not off in reset");
  chk_cfg_one_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $changed(config_one_word) |-> since_fall <= 9'h008)
    else $error("config one changed without command");
  chk_cfg_two_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $changed(config_two_word) |-> since_fall <= 9'h008)
    else $error("config two changed without command");
  chk_busy_start: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_busy_rise |-> since_fall <= 9'h008)
    else $error("busy rose without strobe end");
  chk_busy_bound: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_busy_rise |-> ##[1:400] !command_busy)
    else $error("busy stuck high");
  chk_detect_busy: assert property (@(posedge clk_sys) disable iff (sys_rst)
    detect_current_on |-> command_busy)
    else $error("detect current without busy");
  chk_detect_len: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_detect_end |-> on_cnt == 9'(DETECT_ON_CYC))
    else $error("detect current length wrong");
endmodule
`default_nettype wire

// file: verification/ldscd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ldscd_host_model (
  input  wire logic clk_sys,
  input  wire logic serial_out_line,
  input  wire logic command_busy,
  output logic      shift_clock,
  output logic      serial_in_line,
  output logic      command_strobe
);
  initial begin
    shift_clock    = 1'b0;
    serial_in_line = 1'b0;
    command_strobe = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic sck_pulse;
    shift_clock <= 1'b1;
    tick(4);
    shift_clock <= 1'b0;
    tick(4);
  endtask

  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    @(posedge clk_sys);
    for (int k = 15; k >= 0; k--) begin
      serial_in_line <= w[k];
      tick(4);
      r[k] = serial_out_line;
      sck_pulse();
    end
    serial_in_line <= ~w[0];
  endtask

  task automatic command(input int n);
    @(posedge clk_sys);
    command_strobe <= 1'b1;
    tick(4);
    repeat (n) sck_pulse();
    command_strobe <= 1'b0;
    tick(8);
    while (command_busy) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// file: verification/test_ldscd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module test_ldscd_decoder
  import ldscd_pkg::*;
;
  logic        clk_sys             = 1'b0;
  logic        sys_rst             = 1'b1;
  logic        grayscale_ref_clock = 1'b0;
  logic [15:0] open_detect;
  logic [15:0] short_detect;
  logic        shift_clock;
  logic        serial_in_line;
  logic        command_strobe;
  logic        serial_out_line;
  logic [15:0] sink_channels;
  logic        detect_current_on;
  logic [15:0] config_one_word;
  logic [15:0] config_two_word;
  logic        command_busy;
  logic [15:0] exp_q[$];
  logic [15:0] seen_q[$];
  event        got;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cyc        = 0;

  always #2 clk_sys = ~clk_sys;
  always #62.5 grayscale_ref_clock = ~grayscale_ref_clock;

  ldscd_decoder u_ldscd_decoder (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .grayscale_ref_clock(grayscale_ref_clock),
    .shift_clock(shift_clock), .serial_in_line(serial_in_line), .command_strobe(command_strobe),
    .open_detect(open_detect), .short_detect(short_detect), .serial_out_line(serial_out_line),
    .sink_channels(sink_channels), .detect_current_on(detect_current_on),
    .config_one_word(config_one_word), .config_two_word(config_two_word), .command_busy(command_busy)
  );

  ldscd_host_model u_ldscd_host_model (
    .clk_sys(clk_sys), .serial_out_line(serial_out_line), .command_busy(command_busy),
    .shift_clock(shift_clock), .serial_in_line(serial_in_line), .command_strobe(command_strobe)
  );

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic note(input logic [15:0] e, input logic [15:0] s);
    exp_q.push_back(e);
    seen_q.push_back(s);
    ->got;
  endtask

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(got) begin
    while (exp_q.size() > 0) check(seen_q.pop_front(), exp_q.pop_front());
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      end_sim();
    end
  end

  initial begin
    logic [15:0] w;
    logic [15:0] r;
    logic [15:0] last;
    logic [15:0] c1;
    logic [15:0] c2;
    logic [15:0] p;
    logic [15:0] m;
    logic [15:0] gs [16];
    int          on [16];
    int          cnt [8];
    void'($urandom(32'he62a_f664));
    open_detect  <= 16'($urandom);
    short_detect <= 16'($urandom);
    last = 16'h0000;
    c1 = CFG1_RST;
    c2 = CFG2_RST;
    repeat (140) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    // Config loads, then unassigned counts
    cnt = '{13, 14, 15, 16, 4, 5, 6, 20};
    foreach (cnt[k]) begin
      w = 16'($urandom);
      u_ldscd_host_model.xfer(w, r);
      note(last, r);
      u_ldscd_host_model.command(cnt[k]);
      if (cnt[k] == 13 || cnt[k] == 14) c1 = w;
      if (cnt[k] == 15 || cnt[k] == 16) c2 = w;
      note(c1, config_one_word);
      note(c2, config_two_word);
      last = w;
    end
    // Manual detect, open then short
    for (int k = 0; k < 2; k++) begin
      u_ldscd_host_model.xfer(k ? 16'h0004 : 16'h0002, r);
      u_ldscd_host_model.command(15);
      p = 16'($urandom);
      m = 16'($urandom);
      @(posedge clk_sys);
      open_detect <= p;
      short_detect <= m;
      u_ldscd_host_model.command(9 + k);
      w = 16'($urandom);
      u_ldscd_host_model.xfer(w, r);
      note(k ? ~m : ~p, r);
      u_ldscd_host_model.xfer(16'h0000, r);
      note({1'b0, w[14:0]}, r);
    end
    // PWM in 10-bit async mode with a mask
    u_ldscd_host_model.xfer(16'h000C, r);
    u_ldscd_host_model.command(13);
    u_ldscd_host_model.xfer(16'h0008, r);
    u_ldscd_host_model.command(15);
    m = 16'($urandom);
    u_ldscd_host_model.xfer(m, r);
    u_ldscd_host_model.command(7);
    for (int i = 0; i < 16; i++) begin
      gs[i] = 16'($urandom);
      on[i] = 0;
      u_ldscd_host_model.xfer(gs[i], r);
      u_ldscd_host_model.command(i % 2);
    end
    fork
      u_ldscd_host_model.command(2);
      repeat (1100) begin
        @(negedge grayscale_ref_clock);
        foreach (on[i]) on[i] += sink_channels[i];
      end
    join
    foreach (on[i]) note(m[i] ? gs[i] & 16'h03FF : 16'h0000, 16'(on[i]));
    u_ldscd_host_model.xfer(16'hFFFF, r);
    u_ldscd_host_model.command(8);
    u_ldscd_host_model.command(3);
    repeat (200) @(negedge grayscale_ref_clock);
    u_ldscd_host_model.command(12);
    repeat (3) @(negedge grayscale_ref_clock);
    note(16'h0000, sink_channels);
    u_ldscd_host_model.command(11);
    end_sim();
  end
endmodule

bind ldscd_decoder ldscd_decoder_asserts #(.CHANNELS(CHANNELS)) u_ldscd_decoder_asserts (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .grayscale_ref_clock(grayscale_ref_clock),
  .shift_clock(shift_clock), .serial_in_line(serial_in_line), .command_strobe(command_strobe),
  .open_detect(open_detect), .short_detect(short_detect), .serial_out_line(serial_out_line),
  .sink_channels(sink_channels), .detect_current_on(detect_current_on),
  .config_one_word(config_one_word), .config_two_word(config_two_word), .command_busy(command_busy)
);
`default_nettype wire
